/* hdl/irr_pkg.sv */
// Purpose: Shared constants and carriers of the identity resource responder.
// Assumes: One 40 MHz clock, synchronous active-high reset.
// Notes:   Multi-byte answers go out highest byte first.
//
// Functional notes
// - Serial string holds at most ten ASCII bytes.
// - Serial left justified, unused bytes read 00h.
// - Direct read offsets 0..5 select qualifiers.
// - Serial qualifiers: name, size 10, 0, 15, 0Bh.
// - Bad direct or indirect read answers 13 40.
// - Every direct write answers 14 41.
// - Every indirect write answers 10 41.
// - Indirect read offset indexes first string byte.
// - Indirect read returns at most eight bytes.
// - String bytes sent lowest index first.
// - Revision string holds at most twenty bytes.
// - Firmware part pads trailing bytes with 20h.
// - Hardware revision fills last four bytes, index 16.
// - Hardware revision is HW_ plus letter A..Z.
// - Revision read at 0010h returns four bytes.
// - Offset bits 14..7 ignored, 6..0 used.
// - Revision qualifiers: size 20, 0, 15, 0Bh.
package irr_pkg;

  // ----------------------------------------------------------------
  // Resource identifiers and sizes
  // ----------------------------------------------------------------
  localparam logic [11:0] SERIAL_ID    = 12'h284;
  localparam logic [11:0] REVISION_ID  = 12'h285;
  localparam int          SERIAL_LEN   = 10;
  localparam int          REV_LEN      = 20;
  localparam int          FW_LEN       = 16;
  localparam int          MAX_BYTES    = 8;
  localparam int          IDX_W        = 7;

  // ----------------------------------------------------------------
  // Qualifier selectors and values
  // ----------------------------------------------------------------
  localparam logic [6:0]  Q_NAME       = 7'h00;
  localparam logic [6:0]  Q_SIZE       = 7'h01;
  localparam logic [6:0]  Q_RD_LEVEL   = 7'h02;
  localparam logic [6:0]  Q_WR_LEVEL   = 7'h03;
  localparam logic [6:0]  Q_OVERRUN    = 7'h04;
  localparam logic [6:0]  Q_TYPE       = 7'h05;
  localparam logic [15:0] RD_LEVEL     = 16'h0000;
  localparam logic [15:0] WR_LEVEL     = 16'h000f;
  localparam logic [15:0] TYPE_STRING  = 16'h000b;
  localparam logic [3:0]  NAME_BYTES   = 4'h8;
  localparam logic [3:0]  QUAL_BYTES   = 4'h2;

  // ----------------------------------------------------------------
  // Error codes and fill bytes
  // ----------------------------------------------------------------
  localparam logic [15:0] ERR_READ     = 16'h1340;
  localparam logic [15:0] ERR_DWRITE   = 16'h1441;
  localparam logic [15:0] ERR_IWRITE   = 16'h1041;
  localparam logic [7:0]  SERIAL_FILL  = 8'h00;
  localparam logic [7:0]  FW_FILL      = 8'h20;
  localparam logic [23:0] HW_PREFIX    = 24'h48575f;
  localparam logic [7:0]  HW_FIRST     = 8'h41;
  localparam logic [7:0]  HW_LAST      = 8'h5a;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [11:0] resource_identifier;
    logic        indirect;
    logic        write;
    logic [14:0] offset;
  } irr_req_s;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] err_code;
    logic [3:0]  length;
    logic [63:0] data;
  } irr_rsp_s;

endpackage

/* hdl/irr_responder.sv */
// Purpose: Answers serial number and revision resource requests.
// Assumes: Requester logic runs on mclk; one request per cycle at most.
// Notes:   Answer is a one-cycle pulse on the edge after the request.
`timescale 1ns/10ps
`default_nettype none

module irr_responder #(
  parameter int          SERIAL_CHARS  = 10,
  parameter logic [79:0] SERIAL_TEXT   = 80'h30_30_30_30_30_30_30_30_30_31,
  parameter int          FW_CHARS      = 4,
  parameter logic [127:0] FW_TEXT      = {96'h0, 32'h30_31_2e_31},
  parameter logic [7:0]  HW_LETTER     = 8'h41,
  // Labels are arbitrary neutral text, byte 0 in the top bits.
  parameter logic [63:0] SERIAL_LABEL  = 64'h53_45_52_49_41_4c_4e_52,
  parameter logic [63:0] REVISION_LABEL = 64'h52_45_56_49_53_49_4f_4e,
  parameter logic [15:0] SERIAL_OVERRUN = 16'd180,
  parameter logic [15:0] REV_OVERRUN    = 16'd70
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // Request from the transaction layer
  input  wire irr_pkg::irr_req_s req,
  // Answer to the transaction layer
  output var  irr_pkg::irr_rsp_s rsp
);

  // ----------------------------------------------------------------
  // Constant string storage
  // ----------------------------------------------------------------
  // Text parameters hold byte i at bits [8i+:8]. The stores are plain
  // wires of constants, so reset and accesses never alter them.
  logic [7:0] serial_mem [irr_pkg::SERIAL_LEN];
  logic [7:0] rev_mem    [irr_pkg::REV_LEN];
  logic [7:0] hw_letter_ok;

  // A letter outside A..Z is replaced by A rather than sent as given.
  assign hw_letter_ok = (HW_LETTER >= irr_pkg::HW_FIRST && HW_LETTER <= irr_pkg::HW_LAST)
                      ? HW_LETTER : irr_pkg::HW_FIRST;

  genvar gi;
  generate
    for (gi = 0; gi < irr_pkg::SERIAL_LEN; gi++) begin : g_serial
      assign serial_mem[gi] = (gi < SERIAL_CHARS) ? SERIAL_TEXT[8*gi +: 8]
                                                  : irr_pkg::SERIAL_FILL;
    end
    for (gi = 0; gi < irr_pkg::FW_LEN; gi++) begin : g_fw
      assign rev_mem[gi] = (gi < FW_CHARS) ? FW_TEXT[8*gi +: 8]
                                           : irr_pkg::FW_FILL;
    end
  endgenerate

  assign rev_mem[irr_pkg::FW_LEN]     = irr_pkg::HW_PREFIX[23:16];
  assign rev_mem[irr_pkg::FW_LEN + 1] = irr_pkg::HW_PREFIX[15:8];
  assign rev_mem[irr_pkg::FW_LEN + 2] = irr_pkg::HW_PREFIX[7:0];
  assign rev_mem[irr_pkg::FW_LEN + 3] = hw_letter_ok;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic                     hit;
  logic                     is_serial;
  logic [irr_pkg::IDX_W-1:0] idx;
  logic [7:0]               str_len;
  logic [7:0]               remain;
  logic [3:0]               rd_count;

  assign is_serial = (req.resource_identifier == irr_pkg::SERIAL_ID);
  assign hit       = req.valid && (is_serial ||
                     req.resource_identifier == irr_pkg::REVISION_ID);
  assign idx       = req.offset[irr_pkg::IDX_W-1:0];
  assign str_len   = is_serial ? 8'(irr_pkg::SERIAL_LEN) : 8'(irr_pkg::REV_LEN);
  assign remain    = str_len - {1'b0, idx};
  // Up to eight bytes per answer; the tail read is shorter.
  assign rd_count  = (remain > 8'(irr_pkg::MAX_BYTES)) ? 4'(irr_pkg::MAX_BYTES)
                                                      : remain[3:0];

  // ----------------------------------------------------------------
  // Indirect read lanes
  // ----------------------------------------------------------------
  logic [63:0] str_data;

  generate
    for (gi = 0; gi < irr_pkg::MAX_BYTES; gi++) begin : g_lane
      logic [7:0] pos;
      assign pos = 8'(idx) + 8'(gi);
      // Lane 0 travels in the top byte so it is sent first.
      assign str_data[63 - 8*gi -: 8] =
          (pos >= str_len) ? 8'h00 :
          is_serial        ? serial_mem[pos[3:0]]
                           : rev_mem[pos[4:0]];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Answer selection
  // ----------------------------------------------------------------
  irr_pkg::irr_rsp_s rsp_nxt;

  always_comb begin
    rsp_nxt          = '0;
    rsp_nxt.valid    = hit;
    if (req.write && !req.indirect) begin
      rsp_nxt.error    = 1'b1;
      rsp_nxt.err_code = irr_pkg::ERR_DWRITE;
    end else if (req.write) begin
      // Write level 15 is never granted, so every write fails.
      rsp_nxt.error    = 1'b1;
      rsp_nxt.err_code = irr_pkg::ERR_IWRITE;
    end else if (req.indirect) begin
      if ({1'b0, idx} >= str_len) begin
        rsp_nxt.error    = 1'b1;
        rsp_nxt.err_code = irr_pkg::ERR_READ;
      end else begin
        rsp_nxt.length = rd_count;
        rsp_nxt.data   = str_data;
      end
    end else begin
      rsp_nxt.length = irr_pkg::QUAL_BYTES;
      unique case (idx)
        irr_pkg::Q_NAME: begin
          rsp_nxt.length = irr_pkg::NAME_BYTES;
          rsp_nxt.data   = is_serial ? SERIAL_LABEL : REVISION_LABEL;
        end
        irr_pkg::Q_SIZE:
          rsp_nxt.data[63:48] = {8'h00, str_len};
        irr_pkg::Q_RD_LEVEL:
          rsp_nxt.data[63:48] = irr_pkg::RD_LEVEL;
        irr_pkg::Q_WR_LEVEL:
          rsp_nxt.data[63:48] = irr_pkg::WR_LEVEL;
        irr_pkg::Q_OVERRUN:
          rsp_nxt.data[63:48] = is_serial ? SERIAL_OVERRUN : REV_OVERRUN;
        irr_pkg::Q_TYPE:
          rsp_nxt.data[63:48] = irr_pkg::TYPE_STRING;
        default: begin
          rsp_nxt.length   = 4'h0;
          rsp_nxt.error    = 1'b1;
          rsp_nxt.err_code = irr_pkg::ERR_READ;
        end
      endcase
    end
    // Idle cycles and foreign resources leave every answer field at zero.
    if (!hit) begin
      rsp_nxt = '0;
    end
  end

  // ----------------------------------------------------------------
  // Answer register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp <= rsp_nxt;
    end
  end

endmodule

`default_nettype wire

/* tb/identity_resource_responder_tb.sv */
// Purpose: Self-checking bench for the identity resource responder.
// Assumes: Strings and labels set here by parameter.
// Notes:   Serial text is symmetric since its byte order is a build choice.
`timescale 1ns/10ps
`default_nettype none
module identity_resource_responder_tb;
  localparam logic [11:0] SN = irr_pkg::SERIAL_ID;
  localparam logic [11:0] RV = irr_pkg::REVISION_ID;
  localparam logic [63:0] SL = 64'h53_45_52_4c_41_42_45_4c;
  localparam logic [63:0] RL = 64'h52_45_56_4c_41_42_45_4c;
  localparam logic [1:0]  DR = 2'b00, DW = 2'b01, IR = 2'b10, IW = 2'b11;
  logic              mclk = 1'b0;
  logic              srst = 1'b1;
  irr_pkg::irr_req_s req;
  irr_pkg::irr_rsp_s rsp;
  int                err_count = 0;
  int                samples_checked = 0;
  always #12.5 mclk = ~mclk;
  irr_responder #(.SERIAL_TEXT(80'h41_42_43_44_45_45_44_43_42_41), .FW_CHARS(5),
    .FW_TEXT({88'h0, 40'h34_33_2e_32_31}), .HW_LETTER(8'h43), .SERIAL_LABEL(SL),
    .REVISION_LABEL(RL)) dut (.mclk(mclk), .srst(srst), .req(req), .rsp(rsp));
  irr_master_model mm (.mclk(mclk), .req(req), .rsp(rsp));
  function automatic irr_pkg::irr_rsp_s ok(logic [3:0] n, logic [63:0] d);
    return {2'b10, 16'h0000, n, d};
  endfunction
  function automatic irr_pkg::irr_rsp_s bad(logic [15:0] c);
    return {2'b11, c, 4'h0, 64'h0};
  endfunction
  task automatic run(string n, logic [11:0] id, logic [1:0] m, logic [14:0] off,
                     irr_pkg::irr_rsp_s e);
    irr_pkg::irr_rsp_s got;
    mm.xfer(id, m, off, got);
    samples_checked++;
    if (got !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, got);
    end
  endtask
  task automatic t_quals();
    logic [15:0] v [6] = '{16'h0, 16'h000a, 16'h0, 16'h000f, 16'h00b4, 16'h000b};
    run("serial name", SN, DR, 15'h0080, ok(4'h8, SL));
    run("rev name", RV, DR, 15'h0000, ok(4'h8, RL));
    for (int q = 1; q < 6; q++) begin
      run("serial qual", SN, DR, 15'(q), ok(4'h2, {v[q], 48'h0}));
      run("rev qual", RV, DR, 15'(q),
          ok(4'h2, {q == 1 ? 16'h0014 : (q == 4 ? 16'h0046 : v[q]), 48'h0}));
    end
  endtask
  task automatic t_errors();
    run("dir write", SN, DW, 15'h7fff, bad(irr_pkg::ERR_DWRITE));
    run("dir write", RV, DW, 15'h0000, bad(irr_pkg::ERR_DWRITE));
    run("ind write", SN, IW, 15'h0000, bad(irr_pkg::ERR_IWRITE));
    run("ind write", RV, IW, 15'h0010, bad(irr_pkg::ERR_IWRITE));
    run("dir read 6", RV, DR, 15'h0006, bad(irr_pkg::ERR_READ));
    run("dir read 7f", SN, DR, 15'h007f, bad(irr_pkg::ERR_READ));
    run("serial end", SN, IR, 15'h000a, bad(irr_pkg::ERR_READ));
    run("rev end", RV, IR, 15'h0014, bad(irr_pkg::ERR_READ));
    run("other id", 12'h286, DR, 15'h0000, '0);
  endtask
  task automatic t_serial();
    run("serial 0", SN, IR, 15'h0000, ok(4'h8, 64'h41_42_43_44_45_45_44_43));
    run("serial 8", SN, IR, 15'h0008, ok(4'h2, {16'h4241, 48'h0}));
  endtask
  task automatic t_rev();
    run("rev 0", RV, IR, 15'h0000, ok(4'h8, 64'h31_32_2e_33_34_20_20_20));
    run("rev 3", RV, IR, 15'h0003, ok(4'h8, 64'h33_34_20_20_20_20_20_20));
    run("rev 8", RV, IR, 15'h0008, ok(4'h8, {8{8'h20}}));
    run("rev 16", RV, IR, 15'h0010, ok(4'h4, {32'h48_57_5f_43, 32'h0}));
    run("rev 19", RV, IR, 15'h7f93, ok(4'h1, {8'h43, 56'h0}));
  endtask
  task automatic tally_and_finish();
    $display("err_count=%0d samples_checked=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A hang can only come from the model's fixed waits, so one deadline covers it.
  initial begin
    #100us;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    t_quals();
    t_errors();
    t_serial();
    t_rev();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    t_rev();
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* tb/irr_master_model.sv */
// Purpose: Requesting master on the far side of the responder.
// Assumes: One request per call, answer one edge later.
// Notes:   Idle fields are inverted so a stale request never looks fresh.
`timescale 1ns/10ps
`default_nettype none
module irr_master_model (
  // Clock
  input  wire logic              mclk,
  // Request out, answer back
  output var  irr_pkg::irr_req_s req,
  input  wire irr_pkg::irr_rsp_s rsp
);
  initial req = '0;
  task automatic xfer(input logic [11:0] id, input logic [1:0] m, input logic [14:0] off,
                      output irr_pkg::irr_rsp_s got);
    @(posedge mclk);
    req <= {1'b1, id, m, off};
    @(posedge mclk);
    req <= {1'b0, ~id, ~m, ~off};
    #1 got = rsp;
  endtask
endmodule
`default_nettype wire

/* tb/irr_responder_chk.sv */
// Purpose: Port checker for the identity resource responder.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Answers are judged one edge after the request.
`timescale 1ns/10ps
`default_nettype none
module irr_responder_chk (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              srst,
  // Request and answer
  input wire irr_pkg::irr_req_s req,
  input wire irr_pkg::irr_rsp_s rsp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic       sr = req.valid && req.resource_identifier == irr_pkg::SERIAL_ID;
  wire logic       rv = req.valid && req.resource_identifier == irr_pkg::REVISION_ID;
  wire logic       rd = !req.write && !req.indirect;
  wire logic       ir = !req.write && req.indirect;
  wire logic [6:0] ix = req.offset[6:0];
  chk_answer_latency: assert property ((sr || rv) |=> rsp.valid)
    else $error("no answer one cycle after request");
  chk_other_silent: assert property (req.valid && !sr && !rv |=> !rsp.valid)
    else $error("answer to a foreign resource");
  chk_dwrite_code: assert property ((sr || rv) && req.write && !req.indirect
    |=> rsp.error && rsp.err_code == irr_pkg::ERR_DWRITE) else $error("bad direct write code");
  chk_iwrite_code: assert property ((sr || rv) && req.write && req.indirect
    |=> rsp.error && rsp.err_code == irr_pkg::ERR_IWRITE) else $error("bad indirect write code");
  chk_qual_range: assert property ((sr || rv) && rd && ix > 7'h05
    |=> rsp.err_code == irr_pkg::ERR_READ && rsp.length == 4'h0) else $error("bad qualifier code");
  chk_serial_size: assert property (sr && rd && ix == 7'h01
    |=> rsp.data[63:48] == 16'h000a && rsp.length == 4'h2) else $error("bad serial size");
  chk_rev_size: assert property (rv && rd && ix == 7'h01
    |=> rsp.data[63:48] == 16'h0014 && rsp.length == 4'h2) else $error("bad revision size");
  chk_serial_tail: assert property (sr && ir && ix == 7'h08
    |=> !rsp.error && rsp.length == 4'h2) else $error("bad serial tail length");
  chk_hw_prefix: assert property (rv && ir && ix == 7'h10
    |=> rsp.data[63:40] == irr_pkg::HW_PREFIX && rsp.length == 4'h4) else $error("bad hw field");
  chk_string_end: assert property (sr && ir && ix > 7'h09 || rv && ir && ix > 7'h13
    |=> rsp.err_code == irr_pkg::ERR_READ) else $error("read past string end accepted");
  cover property (rsp.valid && rsp.error);
  cover property (rv && ir && ix == 7'h10 ##1 rsp.valid);
  cover property (sr && rd ##1 rsp.length == 4'h8);
endmodule
bind irr_responder irr_responder_chk u_chk (.mclk(mclk), .srst(srst), .req(req), .rsp(rsp));
`default_nettype wire
